// [pkg/rcr_pkg.sv]
package rcr_pkg;
   localparam logic [7:0] ADDR_SOFT_RESET = 8'h07;
   localparam logic [7:0] ADDR_PIN_OVERRIDE = 8'h08;
   localparam logic [7:0] ADDR_SPARE_A = 8'h09;
   localparam logic [7:0] ADDR_SIG_MONITOR = 8'h0A;
   localparam logic [7:0] ADDR_SPARE_B = 8'h0B;
   localparam logic [7:0] ADDR_SPARE_C = 8'h0C;
   localparam logic [7:0] ADDR_SPARE_D = 8'h0D;
   localparam int BIT_RESET_REGS = 6;
   localparam int BIT_RESET_MASTER = 5;
   localparam int BIT_OVR_THRESHOLD = 6;
   localparam int BIT_OVR_RXDETECT = 3;
   localparam logic [7:0] RST_SOFT_RESET = 8'h01;
   localparam logic [7:0] RST_PIN_OVERRIDE = 8'h00;
   localparam logic [7:0] RST_SPARE_A = 8'h00;
   localparam logic [7:0] RST_SPARE_B = 8'h70;
   localparam logic [7:0] RST_SPARE_C = 8'h00;
   localparam logic [7:0] RST_SPARE_D = 8'h00;
   localparam logic [4:0] RST_SOFT_LOW = 5'h01;
   typedef enum logic [1:0] {
      RCR_RXD_HIZ = 2'b00,
      RCR_RXD_LIMITED = 2'b01,
      RCR_RXD_UNTIL_OK = 2'b10,
      RCR_RXD_FIXED_50 = 2'b11
   } rcr_receive_detect_mode_type;
endpackage : rcr_pkg

// [rtl/rcr_regs.sv]
`timescale 1ns/1ps
module rcr_regs #(
   parameter int CHANNELS = 8
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wr_data_in,
   output logic [7:0] rd_data_out,
   input wire logic threshold_pin_in,
   input wire logic threshold_reg_in,
   input wire logic [1:0] receive_detect_mode_pin_in,
   input wire logic [1:0] receive_detect_mode_reg_in,
   input wire logic [CHANNELS-1:0] signal_lost_in,
   input wire logic test_strap_float_in,
   output logic signal_detect_threshold_select_out,
   output logic [1:0] receive_detect_mode_out,
   output logic receive_detect_mode_hiz_out,
   output logic receive_detect_mode_limited_out,
   output logic receive_detect_mode_until_ok_out,
   output logic receive_detect_mode_fixed_50_out,
   output logic master_reset_out,
   output logic monitor_valid_out
);
   logic [7:0] soft_reset_control;
   logic [7:0] pin_override_control;
   logic [7:0] spare_reg_a;
   logic [7:0] spare_reg_b;
   logic [7:0] spare_reg_c;
   logic [7:0] spare_reg_d;
   logic [7:0] signal_presence_monitor;
   logic regs_reset_pend;
   logic wr_soft;
   logic [1:0] next_mode;
   rcr_pkg::rcr_receive_detect_mode_type mode_sel;

   assign wr_soft = clk_en_in && wr_en_in && addr_in == rcr_pkg::ADDR_SOFT_RESET;

   // Register file with pending soft reset
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         soft_reset_control <= rcr_pkg::RST_SOFT_RESET;
         pin_override_control <= rcr_pkg::RST_PIN_OVERRIDE;
         spare_reg_a <= rcr_pkg::RST_SPARE_A;
         spare_reg_b <= rcr_pkg::RST_SPARE_B;
         spare_reg_c <= rcr_pkg::RST_SPARE_C;
         spare_reg_d <= rcr_pkg::RST_SPARE_D;
         regs_reset_pend <= 1'b0;
      end else if (clk_en_in) begin
         if (regs_reset_pend) begin
            soft_reset_control <= rcr_pkg::RST_SOFT_RESET;
            pin_override_control <= rcr_pkg::RST_PIN_OVERRIDE;
            spare_reg_a <= rcr_pkg::RST_SPARE_A;
            spare_reg_b <= rcr_pkg::RST_SPARE_B;
            spare_reg_c <= rcr_pkg::RST_SPARE_C;
            spare_reg_d <= rcr_pkg::RST_SPARE_D;
            regs_reset_pend <= 1'b0;
         end else begin
            if (wr_soft) begin
               soft_reset_control <= wr_data_in;
               regs_reset_pend <= wr_data_in[rcr_pkg::BIT_RESET_REGS];
            end else begin
               soft_reset_control[rcr_pkg::BIT_RESET_MASTER] <= 1'b0;
            end
            if (wr_en_in) begin
               unique case (addr_in)
                  rcr_pkg::ADDR_PIN_OVERRIDE: pin_override_control <= wr_data_in;
                  rcr_pkg::ADDR_SPARE_A: spare_reg_a <= wr_data_in;
                  rcr_pkg::ADDR_SPARE_B: spare_reg_b <= wr_data_in;
                  rcr_pkg::ADDR_SPARE_C: spare_reg_c <= wr_data_in;
                  rcr_pkg::ADDR_SPARE_D: spare_reg_d <= wr_data_in;
                  default: ;
               endcase
            end
         end
      end
   end

   // Live signal presence capture
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         signal_presence_monitor <= 8'h00;
      end else if (clk_en_in) begin
         signal_presence_monitor <= 8'h00;
         for (int i = 0; i < CHANNELS; i++) begin
            signal_presence_monitor[i] <= signal_lost_in[i];
         end
      end
   end

   assign master_reset_out = soft_reset_control[rcr_pkg::BIT_RESET_MASTER];
   assign monitor_valid_out = test_strap_float_in;

   // Pin or register selection
   assign next_mode = pin_override_control[rcr_pkg::BIT_OVR_RXDETECT]
      ? receive_detect_mode_reg_in : receive_detect_mode_pin_in;

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         signal_detect_threshold_select_out <= 1'b0;
         receive_detect_mode_out <= 2'b00;
      end else if (clk_en_in) begin
         signal_detect_threshold_select_out <= pin_override_control[rcr_pkg::BIT_OVR_THRESHOLD]
            ? threshold_reg_in : threshold_pin_in;
         receive_detect_mode_out <= next_mode;
      end
   end

   // Mode decode
   assign mode_sel = rcr_pkg::rcr_receive_detect_mode_type'(receive_detect_mode_out);
   always_comb begin
      receive_detect_mode_hiz_out = 1'b0;
      receive_detect_mode_limited_out = 1'b0;
      receive_detect_mode_until_ok_out = 1'b0;
      receive_detect_mode_fixed_50_out = 1'b0;
      unique case (mode_sel)
         rcr_pkg::RCR_RXD_HIZ: receive_detect_mode_hiz_out = 1'b1;
         rcr_pkg::RCR_RXD_LIMITED: receive_detect_mode_limited_out = 1'b1;
         rcr_pkg::RCR_RXD_UNTIL_OK: receive_detect_mode_until_ok_out = 1'b1;
         rcr_pkg::RCR_RXD_FIXED_50: receive_detect_mode_fixed_50_out = 1'b1;
      endcase
   end

   // Read data
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_out <= 8'h00;
      end else if (clk_en_in && rd_en_in) begin
         unique case (addr_in)
            rcr_pkg::ADDR_SOFT_RESET: rd_data_out <= soft_reset_control;
            rcr_pkg::ADDR_PIN_OVERRIDE: rd_data_out <= pin_override_control;
            rcr_pkg::ADDR_SPARE_A: rd_data_out <= spare_reg_a;
            rcr_pkg::ADDR_SIG_MONITOR: rd_data_out <= signal_presence_monitor;
            rcr_pkg::ADDR_SPARE_B: rd_data_out <= spare_reg_b;
            rcr_pkg::ADDR_SPARE_C: rd_data_out <= spare_reg_c;
            rcr_pkg::ADDR_SPARE_D: rd_data_out <= spare_reg_d;
            default: rd_data_out <= 8'h00;
         endcase
      end
   end

   property p_regs_reset;
      @(posedge clk_in) disable iff (!reset_n_in)
      (wr_soft && !regs_reset_pend && wr_data_in[rcr_pkg::BIT_RESET_REGS]) ##1 clk_en_in
      |=> pin_override_control == rcr_pkg::RST_PIN_OVERRIDE
         && soft_reset_control == rcr_pkg::RST_SOFT_RESET;
   endproperty
   a_regs_reset: assert property (p_regs_reset) else $error("register reset failed");

   property p_master_clear;
      @(posedge clk_in) disable iff (!reset_n_in)
      (master_reset_out && clk_en_in && !wr_soft) |=> !master_reset_out;
   endproperty
   a_master_clear: assert property (p_master_clear) else $error("master reset stuck");

   property p_master_set;
      @(posedge clk_in) disable iff (!reset_n_in)
      (wr_soft && !regs_reset_pend && wr_data_in[rcr_pkg::BIT_RESET_MASTER]) |=> master_reset_out;
   endproperty
   a_master_set: assert property (p_master_set) else $error("master reset not raised");

   property p_thresh;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && $past(reset_n_in)) |=> signal_detect_threshold_select_out ==
         ($past(pin_override_control[rcr_pkg::BIT_OVR_THRESHOLD])
         ? $past(threshold_reg_in) : $past(threshold_pin_in));
   endproperty
   a_thresh: assert property (p_thresh) else $error("threshold source wrong");

   property p_receive_detect_mode;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && $past(reset_n_in)) |=> receive_detect_mode_out == $past(next_mode);
   endproperty
   a_receive_detect_mode: assert property (p_receive_detect_mode) else $error("receive detect source wrong");

   property p_monitor;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && rd_en_in && addr_in == rcr_pkg::ADDR_SIG_MONITOR) ##1 1'b1
      |-> rd_data_out[CHANNELS-1:0] == $past(signal_presence_monitor[CHANNELS-1:0]);
   endproperty
   a_monitor: assert property (p_monitor) else $error("monitor read wrong");

   property p_onehot;
      @(posedge clk_in) disable iff (!reset_n_in)
      $onehot({receive_detect_mode_hiz_out, receive_detect_mode_limited_out, receive_detect_mode_until_ok_out, receive_detect_mode_fixed_50_out})
         && (receive_detect_mode_fixed_50_out == (receive_detect_mode_out == 2'b11));
   endproperty
   a_onehot: assert property (p_onehot) else $error("mode decode wrong");

   property p_poll;
      @(posedge clk_in) disable iff (!reset_n_in)
      (regs_reset_pend && clk_en_in) |=> !soft_reset_control[rcr_pkg::BIT_RESET_REGS];
   endproperty
   a_poll: assert property (p_poll) else $error("reset bit not cleared");

   property p_pend_once;
      @(posedge clk_in) disable iff (!reset_n_in)
      (regs_reset_pend && clk_en_in) |=> !regs_reset_pend;
   endproperty
   a_pend_once: assert property (p_pend_once) else $error("register reset repeats");

   property p_spares_reset;
      @(posedge clk_in) disable iff (!reset_n_in)
      (regs_reset_pend && clk_en_in) |=> spare_reg_a == rcr_pkg::RST_SPARE_A
         && spare_reg_b == rcr_pkg::RST_SPARE_B
         && spare_reg_c == rcr_pkg::RST_SPARE_C
         && spare_reg_d == rcr_pkg::RST_SPARE_D;
   endproperty
   a_spares_reset: assert property (p_spares_reset) else $error("spare reset failed");

   property p_rd_soft;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && rd_en_in && addr_in == rcr_pkg::ADDR_SOFT_RESET)
      |=> rd_data_out == $past(soft_reset_control);
   endproperty
   a_rd_soft: assert property (p_rd_soft) else $error("reset control read wrong");

   property p_monitor_ro;
      @(posedge clk_in) disable iff (!reset_n_in)
      (clk_en_in && wr_en_in && addr_in == rcr_pkg::ADDR_SIG_MONITOR)
      |=> signal_presence_monitor[CHANNELS-1:0] == $past(signal_lost_in);
   endproperty
   a_monitor_ro: assert property (p_monitor_ro) else $error("monitor was written");

   property p_freeze;
      @(posedge clk_in) disable iff (!reset_n_in)
      !clk_en_in |=> $stable(pin_override_control) && $stable(soft_reset_control)
         && $stable(rd_data_out);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : rcr_regs

// [tb/rcr_host.sv]
`timescale 1ns/1ps
module rcr_host (
   input wire logic clk_in,
   input wire logic [7:0] rd_data_in,
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [7:0] addr_out,
   output logic [7:0] wr_data_out
);
   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = 8'h00;
      wr_data_out = 8'h00;
   end
   // Single byte write, released bus shows inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      wr_en_out <= 1'b1;
      addr_out <= a;
      wr_data_out <= d;
      @(posedge clk_in);
      wr_en_out <= 1'b0;
      addr_out <= ~a;
      wr_data_out <= ~d;
   endtask : wr
   // Single byte read
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      rd_en_out <= 1'b1;
      addr_out <= a;
      @(posedge clk_in);
      rd_en_out <= 1'b0;
      addr_out <= ~a;
      @(posedge clk_in);
      #1 d = rd_data_in;
   endtask : rd
endmodule : rcr_host

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic wr, rd, tp, tr, thr, mrst, vld, h, l, u, f;
   logic [7:0] ad, wd, rdd;
   logic [7:0] lost = 8'h00;
   logic [1:0] mp = 2'h2;
   logic [1:0] mr = 2'h1;
   logic [1:0] mo;
   logic strap = 1'b1;
   logic en = 1'b1;
   int fails = 0;
   int n_compared = 0;
   always #20 clk_in = ~clk_in;
   initial begin
      tp = 1'b1;
      tr = 1'b0;
   end
   rcr_host i_rcr_host (.clk_in(clk_in), .rd_data_in(rdd), .wr_en_out(wr), .rd_en_out(rd),
      .addr_out(ad), .wr_data_out(wd));
   rcr_regs i_rcr_regs (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(en),
      .wr_en_in(wr), .rd_en_in(rd), .addr_in(ad), .wr_data_in(wd), .rd_data_out(rdd),
      .threshold_pin_in(tp), .threshold_reg_in(tr), .receive_detect_mode_pin_in(mp),
      .receive_detect_mode_reg_in(mr), .signal_lost_in(lost), .test_strap_float_in(strap),
      .signal_detect_threshold_select_out(thr), .receive_detect_mode_out(mo),
      .receive_detect_mode_hiz_out(h), .receive_detect_mode_limited_out(l), .receive_detect_mode_until_ok_out(u),
      .receive_detect_mode_fixed_50_out(f), .master_reset_out(mrst), .monitor_valid_out(vld));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_rcr_host.rd(a, d);
      chk(d, e);
   endtask : rdchk
   task automatic t_defaults;
      rdchk(8'h07, 8'h01);
      rdchk(8'h08, 8'h00);
      rdchk(8'h09, 8'h00);
      rdchk(8'h0A, 8'h00);
      rdchk(8'h0B, 8'h70);
      rdchk(8'h0C, 8'h00);
      rdchk(8'h0D, 8'h00);
   endtask : t_defaults
   task automatic t_override;
      i_rcr_host.wr(8'h08, 8'h00);
      repeat (3) @(posedge clk_in);
      #1 chk({7'h00, thr}, 8'h01);
      chk({6'h00, mo}, 8'h02);
      i_rcr_host.wr(8'h08, 8'h48);
      repeat (3) @(posedge clk_in);
      #1 chk({7'h00, thr}, 8'h00);
      chk({6'h00, mo}, 8'h01);
      rdchk(8'h08, 8'h48);
   endtask : t_override
   task automatic t_decode;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_in);
         mr <= m[1:0];
         repeat (3) @(posedge clk_in);
         #1 chk({4'h0, f, u, l, h}, 8'h01 << m);
      end
   endtask : t_decode
   task automatic t_monitor;
      @(posedge clk_in);
      lost <= 8'hA5;
      i_rcr_host.wr(8'h0A, 8'h00);
      rdchk(8'h0A, 8'hA5);
      chk({7'h00, vld}, 8'h01);
      @(posedge clk_in);
      strap <= 1'b0;
      #1 chk({7'h00, vld}, 8'h00);
   endtask : t_monitor
   task automatic t_regreset;
      i_rcr_host.wr(8'h0B, 8'h70);
      i_rcr_host.wr(8'h07, 8'h41);
      repeat (2) @(posedge clk_in);
      rdchk(8'h08, 8'h00);
      rdchk(8'h07, 8'h01);
   endtask : t_regreset
   task automatic t_master;
      i_rcr_host.wr(8'h07, 8'h21);
      #1 chk({7'h00, mrst}, 8'h01);
      @(posedge clk_in);
      #1 chk({7'h00, mrst}, 8'h00);
      rdchk(8'h07, 8'h01);
   endtask : t_master
   task automatic t_freeze;
      @(posedge clk_in);
      en <= 1'b0;
      i_rcr_host.wr(8'h08, 8'h48);
      @(posedge clk_in);
      en <= 1'b1;
      rdchk(8'h08, 8'h00);
   endtask : t_freeze
   task automatic final_report;
      $display("Compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report
   initial begin
      #100000;
      fails++;
      final_report();
   end
   initial begin
      repeat (6) @(posedge clk_in);
      reset_n_in <= 1'b1;
      t_defaults();
      t_override();
      t_decode();
      t_monitor();
      t_regreset();
      t_master();
      t_freeze();
      final_report();
   end
endmodule : tb_top
